// ===== tsp_map.svh
/*
 Register map, field positions, reset values and counts of the
 shared-scaler timer block.
 Assumes a 32-bit classic Wishbone slave, byte address = 4 * index.
*/
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// Register indices, byte address is four times the index
`define TSP_IDX_TIMER 8'h01
`define TSP_IDX_INTCTL 8'h0b
`define TSP_IDX_OPTION 8'h81
`define TSP_IDX_PORTADIR 8'h85

// Reset values
`define TSP_RST_TIMER 8'h00
`define TSP_RST_INTCTL 8'h00
`define TSP_RST_OPTION 8'hff
`define TSP_RST_PORTADIR 8'h3f
`define TSP_RST_SCALER 8'h00

// Field positions in interrupt_control
`define TSP_BIT_OVF_EN 5
`define TSP_BIT_OVF_FLAG 2

// Implemented bits of port_a_direction
`define TSP_MASK_PORTADIR 8'h3f

// Instruction cycles of count inhibit after a timer write
`define TSP_INHIBIT_CYC 2'h2

`endif

// ===== tsp_pkg.sv
/*
 Types of the shared-scaler timer block.
 Assumes tsp_map.svh holds the numeric constants.
*/
package tsp_pkg;

    // Option configuration fields, bit 7 down to bit 0
    typedef struct packed {
        logic pullup_disable_n;
        logic ext_int_edge_sel;
        logic timer_clock_source_sel;
        logic timer_source_edge_sel;
        logic scaler_assign_sel;
        logic [2:0] scaler_rate_sel;
    } tsp_option_t;

    // Internal phase clocks, one-hot
    typedef enum logic [3:0] {
        PH_ONE = 4'b0001,
        PH_TWO = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR = 4'b1000
    } tsp_phase_t;

endpackage

// ===== tsp_timer.sv
/*
 8-bit timer/counter with one 8-bit scaler shared between timer
 (prescaler) and watchdog (postscaler), plus the option register.
 Assumes: classic Wishbone master on clk_i, core strobes on clk_i,
 external clock pin asynchronous, watchdog tick on clk_i.
*/
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "tsp_map.svh"

// Contract
// - Unassigned scaler passes external clock straight through
// - Scaler output sampled on phase two and four
// - Option bit 7 disables port A pull-ups
// - Option bit 6 selects interrupt pin edge
// - Option bit 5 selects pin or cycle clock
// - Option bit 4 selects falling or rising pin edge
// - Option bit 3 gives scaler to watchdog
// - Rate code divides timer 2^(n+1), watchdog 2^n
// - One 8-bit scaler, timer or watchdog only
// - Scaler has no software read or write
// - Timer write clears scaler when timer-assigned
// - Watchdog clear clears scaler when watchdog-assigned
// - Assignment may change any time, no reset
// - Option register at 81h, resets all ones
// - Internal clock, no scaler: one count per cycle
// - Timer write blocks counting two instruction cycles
// - Rollover FFh to 00h sets overflow flag
// - Timer stopped during sleep
module tsp_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Core and pins
    input wire logic timer_ext_clock_pin_i,
    input wire logic sleep_i,
    input wire logic wdt_clear_i,
    input wire logic wdt_tick_i,
    // Outward controls
    output tsp_pkg::tsp_option_t option_o,
    output logic [7:0] port_a_direction_o,
    output logic timer_int_o,
    output logic wdt_post_o,
    output logic wdt_clear_o
);
    import tsp_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Functions
    ////////////////////////////////////////////////////////////////

    // Low-bit mask for a watchdog division of 2^code
    function automatic logic [7:0] rate_mask(input logic [2:0] code);
        logic [7:0] one;
        one = 8'h01;
        rate_mask = 8'((one << code) - one);
    endfunction

    // Register index hit test
    function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
        idx_hit = (idx == want);
    endfunction

    ////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////

    tsp_phase_t phase_ff; // Current phase clock
    tsp_phase_t nxt_phase;
    logic pin_meta_ff; // First synchroniser stage
    logic pin_sync_ff; // Second synchroniser stage
    logic src_prev_ff; // Source level, last cycle
    logic samp_ff; // Scaler output sampled on phase clocks
    logic [7:0] scaler_ff; // Shared scaler, hidden from software
    logic [7:0] nxt_scaler;
    logic [7:0] timer_count_ff; // Timer count register
    logic [7:0] nxt_timer_count;
    logic [7:0] intctl_ff; // Interrupt control register
    logic [7:0] nxt_intctl;
    tsp_option_t option_ff; // Option configuration register
    tsp_option_t nxt_option;
    logic [7:0] portadir_ff; // Port A direction register
    logic [7:0] nxt_portadir;
    logic [1:0] inhibit_ff; // Instruction cycles left without counting
    logic [1:0] nxt_inhibit;
    logic ack_ff; // Bus acknowledge
    logic [31:0] dat_ff; // Bus read data
    logic timer_int_ff; // Overflow interrupt request
    logic wdt_post_ff; // Postscaler tick to the watchdog
    logic wdt_clear_ff; // Watchdog clear to the watchdog

    ////////////////////////////////////////////////////////////////
    // Bus decode
    ////////////////////////////////////////////////////////////////

    wire logic [7:0] idx = adr_i[9:2]; // Word index
    wire logic take = cyc_i & stb_i & ~ack_ff; // Request taken now
    wire logic wr_lane = take & we_i & sel_i[0]; // Low byte written
    wire logic hit_tmr = idx_hit(idx, `TSP_IDX_TIMER);
    wire logic hit_int = idx_hit(idx, `TSP_IDX_INTCTL);
    wire logic hit_opt = idx_hit(idx, `TSP_IDX_OPTION);
    wire logic hit_pad = idx_hit(idx, `TSP_IDX_PORTADIR);
    wire logic wr_tmr = wr_lane & hit_tmr; // Any timer write
    wire logic wr_int = wr_lane & hit_int;
    wire logic wr_opt = wr_lane & hit_opt;
    wire logic wr_pad = wr_lane & hit_pad;

    // Read selection, unmapped reads zero; the scaler is not mapped
    wire logic [7:0] rd_byte =
        hit_tmr ? timer_count_ff :
        hit_int ? intctl_ff :
        hit_opt ? option_ff :
        hit_pad ? portadir_ff :
        8'h00;

    ////////////////////////////////////////////////////////////////
    // Clock selection and scaler
    ////////////////////////////////////////////////////////////////

    // Option fields in use
    wire logic use_pin = option_ff.timer_clock_source_sel;
    wire logic fall_edge = option_ff.timer_source_edge_sel;
    wire logic to_wdt = option_ff.scaler_assign_sel;
    wire logic [2:0] rate = option_ff.scaler_rate_sel;

    // Instruction-cycle clock level, high in phases three and four
    wire logic cyc_lvl = (phase_ff == PH_THREE) | (phase_ff == PH_FOUR);

    // Falling pin edges become rising ones by inversion
    wire logic pin_lvl = pin_sync_ff ^ fall_edge;

    // Source ahead of the scaler
    wire logic src = use_pin ? pin_lvl : cyc_lvl;
    wire logic src_rise = src & ~src_prev_ff;

    // Scaler bit that rises every 2^(code+1) source edges
    wire logic div_bit = scaler_ff[rate];

    // Watchdog-assigned scaler hands the source straight on
    wire logic pre_out = to_wdt ? src : div_bit;

    // Sampling points of the synchroniser
    wire logic samp_now = (phase_ff == PH_TWO) | (phase_ff == PH_FOUR);
    wire logic sync_rise = samp_now & pre_out & ~samp_ff;

    // Counting gate: no sleep, no pending inhibit
    wire logic inc = sync_rise & ~sleep_i & (inhibit_ff == 2'h0);

    // Rollover from the top count
    wire logic ovf = inc & ~wr_tmr & (timer_count_ff == 8'hff);

    // Scaler clears per assignment
    wire logic scl_clr = (wr_tmr & ~to_wdt) | (wdt_clear_i & to_wdt);

    // Scaler count events per assignment
    wire logic scl_step = to_wdt ? wdt_tick_i : src_rise;

    // Scaler value after this step
    wire logic [7:0] scl_up = 8'(scaler_ff + 8'h01);

    // Watchdog postscaler output, 1:1 at code zero
    wire logic post_hit = to_wdt & wdt_tick_i & ~scl_clr
        & ((scl_up & rate_mask(rate)) == 8'h00);

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    ////////////////////////////////////////////////////////////////

    // Phase rotation
    always_comb begin
        unique case (phase_ff)
            PH_ONE: begin
                nxt_phase = PH_TWO;
            end
            PH_TWO: begin
                nxt_phase = PH_THREE;
            end
            PH_THREE: begin
                nxt_phase = PH_FOUR;
            end
            PH_FOUR: begin
                nxt_phase = PH_ONE;
            end
            default: begin
                nxt_phase = PH_ONE;
            end
        endcase
    end

    // Scaler: clear, count or hold
    always_comb begin
        if (scl_clr) begin
            nxt_scaler = `TSP_RST_SCALER;
        end else if (scl_step) begin
            nxt_scaler = scl_up;
        end else begin
            nxt_scaler = scaler_ff;
        end
    end

    // Timer count: write wins over increment
    always_comb begin
        if (wr_tmr) begin
            nxt_timer_count = dat_i[7:0];
        end else if (inc) begin
            nxt_timer_count = 8'(timer_count_ff + 8'h01);
        end else begin
            nxt_timer_count = timer_count_ff;
        end
    end

    // Inhibit window after a timer write, ends at phase four
    always_comb begin
        if (wr_tmr) begin
            nxt_inhibit = `TSP_INHIBIT_CYC;
        end else if ((phase_ff == PH_FOUR) && (inhibit_ff != 2'h0)) begin
            nxt_inhibit = 2'(inhibit_ff - 2'h1);
        end else begin
            nxt_inhibit = inhibit_ff;
        end
    end

    // Interrupt control: overflow set beats a software clear
    always_comb begin
        nxt_intctl = wr_int ? dat_i[7:0] : intctl_ff;
        if (ovf) begin
            nxt_intctl[`TSP_BIT_OVF_FLAG] = 1'b1;
        end
    end

    // Option register, writable at any time
    always_comb begin
        nxt_option = wr_opt ? tsp_option_t'(dat_i[7:0]) : option_ff;
    end

    // Port A direction, upper bits unimplemented
    always_comb begin
        nxt_portadir = wr_pad ? (dat_i[7:0] & `TSP_MASK_PORTADIR) : portadir_ff;
    end

    ////////////////////////////////////////////////////////////////
    // Pin synchroniser
    ////////////////////////////////////////////////////////////////

    // Two stages before any logic looks at the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else if (ce_i) begin
            pin_meta_ff <= timer_ext_clock_pin_i;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Timing state
    ////////////////////////////////////////////////////////////////

    // Phase, source edge history and phase-clock sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= PH_ONE;
            // Reset option inverts the idle-low pin to level one: no false edge
            src_prev_ff <= 1'b1;
            samp_ff <= 1'b1;
        end else if (ce_i) begin
            phase_ff <= nxt_phase;
            src_prev_ff <= src;
            if (samp_now) begin
                samp_ff <= pre_out;
            end
        end
    end

    // Scaler and inhibit window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scaler_ff <= `TSP_RST_SCALER;
            inhibit_ff <= 2'h0;
        end else if (ce_i) begin
            scaler_ff <= nxt_scaler;
            inhibit_ff <= nxt_inhibit;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////

    // Software-visible registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_ff <= `TSP_RST_TIMER;
            intctl_ff <= `TSP_RST_INTCTL;
            option_ff <= tsp_option_t'(`TSP_RST_OPTION);
            portadir_ff <= `TSP_RST_PORTADIR;
        end else if (ce_i) begin
            timer_count_ff <= nxt_timer_count;
            intctl_ff <= nxt_intctl;
            option_ff <= nxt_option;
            portadir_ff <= nxt_portadir;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus answer
    ////////////////////////////////////////////////////////////////

    // One-cycle acknowledge with registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_ff <= take;
            if (take) begin
                dat_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outward strobes
    ////////////////////////////////////////////////////////////////

    // Interrupt request and watchdog strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_int_ff <= 1'b0;
            wdt_post_ff <= 1'b0;
            wdt_clear_ff <= 1'b0;
        end else if (ce_i) begin
            timer_int_ff <= nxt_intctl[`TSP_BIT_OVF_FLAG]
                & nxt_intctl[`TSP_BIT_OVF_EN];
            wdt_post_ff <= post_hit;
            wdt_clear_ff <= wdt_clear_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////

    // Pull-up disable and interrupt edge leave with the option
    assign option_o = option_ff;
    assign port_a_direction_o = portadir_ff;
    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
    assign timer_int_o = timer_int_ff;
    assign wdt_post_o = wdt_post_ff;
    assign wdt_clear_o = wdt_clear_ff;

endmodule

// ===== tsp_timer_monitor.sv
/*
 Checker of the shared-scaler timer, bound to its top ports.
 Assumes one clock clk_i and the synchronous reset rst_i.
*/
`timescale 1ns/1ps
`include "tsp_map.svh"
module tsp_timer_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic wdt_clear_i,
    input wire logic wdt_tick_i,
    input wire tsp_pkg::tsp_option_t option_o,
    input wire logic timer_int_o,
    input wire logic wdt_post_o,
    input wire logic wdt_clear_o
);
    import tsp_pkg::*;
    // Bus decode
    wire take = cyc_i && stb_i && !ack_o && ce_i;
    wire [7:0] idx = adr_i[9:2];
    wire opt_wr = take && we_i && sel_i[0] && (idx == `TSP_IDX_OPTION);
    wire mapped = (idx == `TSP_IDX_TIMER) || (idx == `TSP_IDX_INTCTL) ||
        (idx == `TSP_IDX_OPTION) || (idx == `TSP_IDX_PORTADIR);
    // Shadow of the overflow interrupt enable
    logic int_en_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_en_ff <= 1'b0;
        end else if (take && we_i && sel_i[0] && idx == `TSP_IDX_INTCTL) begin
            int_en_ff <= dat_i[`TSP_BIT_OVF_EN];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    chk_opt_reset: assert property (disable iff (1'b0) rst_i |=> option_o == `TSP_RST_OPTION)
        else $error("option not all ones after reset");
    chk_opt_write: assert property (opt_wr |=> option_o == $past(dat_i[7:0]))
        else $error("option write lost");
    chk_opt_hold: assert property (!opt_wr |=> $stable(option_o))
        else $error("option changed without write");
    chk_read_zero: assert property (take && !we_i && !mapped |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_wdt_clear: assert property (wdt_clear_i && ce_i |=> wdt_clear_o)
        else $error("watchdog clear not passed on");
    chk_post_timer: assert property (!option_o[3] && !$past(option_o[3]) |-> !wdt_post_o)
        else $error("postscaler pulse while timer owns scaler");
    chk_post_rate: assert property (wdt_tick_i && !wdt_clear_i && ce_i && option_o[3] &&
        option_o[2:0] == 3'h0 |-> ##[1:2] wdt_post_o)
        else $error("one to one postscale missed a tick");
    chk_post_gap: assert property (wdt_post_o && option_o[2:0] != 3'h0 && $stable(option_o)
        |=> !wdt_post_o)
        else $error("postscale pulses too close");
    chk_int_mask: assert property (!int_en_ff && !$past(int_en_ff) |-> !timer_int_o)
        else $error("interrupt while masked");
    cov_opt: cover property (opt_wr);
    cov_post: cover property (wdt_post_o);
    cov_int: cover property (timer_int_o);
endmodule
bind tsp_timer tsp_timer_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .wdt_clear_i(wdt_clear_i), .wdt_tick_i(wdt_tick_i),
    .option_o(option_o), .timer_int_o(timer_int_o), .wdt_post_o(wdt_post_o),
    .wdt_clear_o(wdt_clear_o));

// ===== tsp_pin_model.sv
/*
 External timer clock pin: sends count_i pulses of HALF clocks high and low.
 Assumes start_i is a one-cycle request; the pin stands still between bursts.
*/
`timescale 1ns/1ps
module tsp_pin_model #(parameter int HALF = 4) (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [7:0] count_i,
    input wire logic end_high_i,
    output logic pin_o,
    output logic busy_o
);
    // Burst engine, optionally leaving the pin high at the end
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (start_i) begin
                busy_o <= 1'b1;
                for (int i = 0; i < count_i; i++) begin
                    repeat (HALF) @(posedge clk_i);
                    pin_o <= 1'b1;
                    repeat (HALF) @(posedge clk_i);
                    pin_o <= 1'b0;
                end
                repeat (HALF) @(posedge clk_i);
                if (end_high_i) begin
                    pin_o <= 1'b1;
                end
                repeat (HALF) @(posedge clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule

// ===== tb_timer0_shared_prescaler.sv
/*
 Self-checking bench of the shared-scaler timer.
 Assumes the map header and the pin model; reads are checked off a queue.
*/
`timescale 1ns/1ps
`include "tsp_map.svh"
module tb_timer0_shared_prescaler;
    import tsp_pkg::*;
    localparam logic [9:0] A_TMR = {`TSP_IDX_TIMER, 2'b00};
    localparam logic [9:0] A_INT = {`TSP_IDX_INTCTL, 2'b00};
    localparam logic [9:0] A_OPT = {`TSP_IDX_OPTION, 2'b00};
    localparam logic [9:0] A_DIR = {`TSP_IDX_PORTADIR, 2'b00};
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0, ce_i = 1;
    logic wdt_clear_i = 0, wdt_tick_i = 0, start = 0, end_high = 0, pin, busy;
    logic [9:0] adr_i = 0;
    logic [31:0] dat_i = 0, dat_o, rnd = 32'h363c;
    logic [7:0] cnt = 0, dir_o, q_lo[$], q_sp[$];
    logic ack_o, int_o, post_o, clr_o;
    tsp_option_t opt_o;
    int n_mismatch = 0, compares = 0, n_cyc = 0;
    tsp_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .timer_ext_clock_pin_i(pin), .sleep_i(sleep_i), .wdt_clear_i(wdt_clear_i),
        .wdt_tick_i(wdt_tick_i), .option_o(opt_o), .port_a_direction_o(dir_o),
        .timer_int_o(int_o), .wdt_post_o(post_o), .wdt_clear_o(clr_o));
    tsp_pin_model #(.HALF(4)) u_pin (.clk_i(clk_i), .start_i(start), .count_i(cnt),
        .end_high_i(end_high), .pin_o(pin), .busy_o(busy));
    always #25 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Random watchdog ticks and the hang guard
    always @(posedge clk_i) begin
        rnd <= lfsr(rnd);
        wdt_tick_i <= (rnd[1:0] == 2'b00);
        n_cyc++;
        if (n_cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] sp);
        logic [7:0] d;
        d = got - lo;
        compares++;
        if ((d <= sp) !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h want=%h+%h", $time, got, lo, sp);
        end
    endtask
    // Read results taken off the queue at the ack edge
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0 && q_lo.size() > 0) begin
            cmp(dat_o[7:0], q_lo.pop_front(), q_sp.pop_front());
        end
    end
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
        input logic [7:0] lo, input logic [7:0] sp);
        if (!w) begin
            q_lo.push_back(lo);
            q_sp.push_back(sp);
        end
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0000_00, d};
        @(posedge clk_i);
        // Wait for the answer; only the cycle ceiling ends a hang
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic clr_wdt;
        wdt_clear_i <= 1'b1;
        @(posedge clk_i);
        wdt_clear_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Safe reassignment of the scaler, then read back
    task automatic set_opt(input logic [7:0] v);
        clr_wdt();
        wb(1, A_TMR, 8'h00, 0, 0);
        if (v[3] && v[2:1] == 2'b00) begin
            wb(1, A_OPT, 8'h2f, 0, 0);
            clr_wdt();
        end
        wb(1, A_OPT, v, 0, 0);
        wb(0, A_OPT, 0, v, 0);
    endtask
    // Timer count after w clocks, divided by 2^sh, frozen when sl
    task automatic cnt_chk(input int w, input int sh, input logic sl);
        logic [7:0] v;
        int n;
        v = rnd[7:0] & 8'h3f;
        n = (w + 3) / 4;
        wb(1, A_TMR, v, 0, 0);
        repeat (w) @(posedge clk_i);
        if (sl) wb(0, A_TMR, 0, v, 0);
        else if (sh == 0) wb(0, A_TMR, 0, 8'(v + n - 3), 2);
        else wb(0, A_TMR, 0, 8'(v + (n >> sh) - 1), 2);
    endtask
    task automatic pulse(input logic [7:0] k, input logic hi, input logic [7:0] e);
        wb(1, A_TMR, 8'h00, 0, 0);
        repeat (12) @(posedge clk_i);
        cnt <= k;
        end_high <= hi;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        @(posedge clk_i);
        while (busy !== 1'b0) begin
            @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        wb(0, A_TMR, 0, e, 0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, A_OPT, 0, `TSP_RST_OPTION, 0);
        wb(0, A_INT, 0, `TSP_RST_INTCTL, 0);
        wb(0, A_DIR, 0, `TSP_RST_PORTADIR, 0);
        wb(1, A_DIR, 8'hff, 0, 0);
        cmp(dir_o, `TSP_MASK_PORTADIR, 0);
        wb(0, A_DIR, 0, `TSP_MASK_PORTADIR, 0);
        wb(1, 10'h3fc, 8'h55, 0, 0);
        wb(0, 10'h3fc, 0, 8'h00, 0);
        set_opt(8'h08);
        cnt_chk(200, 0, 0);
        sleep_i <= 1'b1;
        cnt_chk(100, 0, 1);
        sleep_i <= 1'b0;
        // Clock enable low freezes count, phase and inhibit alike
        wb(1, A_TMR, 8'h10, 0, 0);
        ce_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        ce_i <= 1'b1;
        wb(0, A_TMR, 0, 8'h10, 0);
        for (int r = 0; r < 8; r++) begin
            set_opt(8'(r));
            cnt_chk(80 << r, r + 1, 0);
        end
        set_opt(8'h08);
        wb(1, A_INT, 8'h20, 0, 0);
        wb(1, A_TMR, 8'hfe, 0, 0);
        repeat (30) @(posedge clk_i);
        cmp({7'h00, int_o}, 8'h01, 0);
        wb(0, A_INT, 0, 8'h24, 0);
        wb(1, A_INT, 8'h20, 0, 0);
        repeat (2) @(posedge clk_i);
        cmp({7'h00, int_o}, 8'h00, 0);
        wb(1, A_INT, 8'h00, 0, 0);
        wb(1, A_TMR, 8'hfe, 0, 0);
        repeat (30) @(posedge clk_i);
        wb(0, A_INT, 0, 8'h04, 0);
        set_opt(8'h29);
        pulse(8'd5, 1'b1, 8'd6);
        set_opt(8'h39);
        pulse(8'd5, 1'b0, 8'd5);
        end_sim();
    end
endmodule
